// File: ecr_capability_regs.sv
// Read-only capability register bank of the high-speed host controller
//
// Functional notes
// RL1 - Version and length word at offset zero
// RL2 - Interface version is BCD encoded
// RL3 - Length byte locates operational register space
// RL4 - Structural word at 04h, reserved bits zero
// RL5 - Bits 15..12 give companion count, two
// RL6 - Zero companions: no hand-off, high-speed only
// RL7 - Nonzero companions: hand-off supported
// RL8 - Bits 11..8 give ports per companion, one
// RL9 - Per-companion size consistent with port counts
// RL10 - Routing bit zero: ascending grouped routing
// RL11 - Routing bit one: explicit route array, one
// RL12 - Bit 4 reports port power switches, one
// RL13 - Bits 3..0 give port count, two
// RL14 - Writes ignored, reserved bits read zero
`timescale 1ns/1ns
`default_nettype none

module ecr_capability_regs
    import ecr_pkg::*;
#(
    parameter logic [15:0] INTERFACE_VERSION    = ECR_RST_VERSION,
    parameter logic [7:0]  CAPABILITY_LENGTH    = ECR_RST_CAP_LENGTH,
    parameter logic [3:0]  COMPANION_COUNT      = ECR_RST_COMPANIONS,
    parameter logic [3:0]  PORTS_PER_COMPANION  = ECR_RST_PORTS_PER_CC,
    parameter logic        ROUTING_RULE         = ECR_RST_ROUTING_RULE,
    parameter logic        POWER_SWITCH_PRESENT = ECR_RST_POWER_SWITCH,
    parameter logic [3:0]  PORT_COUNT           = ECR_RST_PORT_COUNT
)
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [7:0]  req_addr,
    input  wire logic [31:0] req_wdata,
    output logic             ack_q,
    output logic [31:0]      rdata_q,
    output logic             err_q,
    output logic [7:0]       op_base_q,
    output logic             handoff_supported_q,
    output logic             high_speed_only_q,
    output logic             explicit_routing_q,
    output logic             config_ok_q
);

    // The bank is static: every field is a build-time parameter, and no access
    // can change it. Beyond the reset stages, the clocked state is the answer path and the status
    // levels that the neighbouring blocks read. Software that writes here gets
    // a plain answer and no side effect, so a stray write is harmless.

    // Reset synchroniser stages
    logic        rst_meta_q;   // First stage, read only by the second
    logic        rst_sync_q;   // Released reset used by the rest
    logic        rst_n;        // Local alias of the released reset

    // Static capability view
    ecr_caps_t   caps;         // Fields fed to the packer
    logic [31:0] version_word; // Packed version word
    logic [31:0] struct_word;  // Packed structural word
    logic        cfg_ok;       // Consistency of the field set

    // Request carrier and decode
    ecr_req_t    req;          // Bundled request from the ports
    logic        hit_version;  // Request addresses the version word
    logic        hit_struct;   // Request addresses the structural word
    logic        misaligned;   // Low address bits not zero
    logic [31:0] read_mux;     // Word selected for a read

    // Decode of one byte address against a word offset
    function automatic logic addr_hits(input logic [7:0] a, input logic [7:0] ofs);
        addr_hits = (a[7:2] == ofs[7:2]);
    endfunction

    // Reset is asserted at once and released on the clock
    // Two stages keep a reset that ends near a clock edge from leaving some
    // flops in reset and others out; the first stage feeds only the second.
    // Assertion stays immediate so a dropped reset clears the answer at once.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_n = rst_sync_q;

    // Fields are fixed at build time; parameters keep one source of truth
    // Changing a default here moves the words and the status levels together
    // A field set that breaks the grouping rule still builds; config_ok_q shows it
    always_comb begin
        caps.interface_version    = INTERFACE_VERSION;    // [RL2]
        caps.capability_length    = CAPABILITY_LENGTH;    // [RL3]
        caps.companion_count      = COMPANION_COUNT;      // [RL5]
        caps.ports_per_companion  = PORTS_PER_COMPANION;  // [RL8]
        caps.routing_rule         = ROUTING_RULE;         // [RL11]
        caps.power_switch_present = POWER_SWITCH_PRESENT; // [RL12]
        caps.port_count           = PORT_COUNT;           // [RL13]
    end

    // Field packing and consistency check
    // The packer owns the reserved-bit zeroing, so both words share one rule
    ecr_word_pack u_pack (
        .caps         (caps),
        .version_word (version_word),
        .struct_word  (struct_word),
        .config_ok    (cfg_ok)
    );

    // Bundle the request; write data is carried but never stored
    always_comb begin
        req.valid = req_valid;
        req.write = req_write;
        req.addr  = req_addr;
        req.wdata = req_wdata;
    end

    // Address decode; misaligned accesses are refused as unmapped
    // Only whole words exist; answering a partial access with a shifted word
    // would hand software a value that it could misread as a field
    always_comb begin
        misaligned  = (req.addr[1:0] != 2'b00);
        hit_version = addr_hits(req.addr, ECR_OFS_CAP_VERSION) && !misaligned; // [RL1]
        hit_struct  = addr_hits(req.addr, ECR_OFS_STRUCT_PARAMS) && !misaligned; // [RL4]
    end

    // Read selection; anything unmapped reads as zero
    // Zero rather than the last word keeps stale data off the answer
    // Limitation: software cannot tell a refused read from a zero word by data
    always_comb begin
        if (hit_version) begin
            read_mux = version_word; // [RL1]
        end else if (hit_struct) begin
            read_mux = struct_word; // [RL4]
        end else begin
            read_mux = 32'h0000_0000;
        end
    end

    // Every request is answered exactly one cycle later
    // No wait states: a request every cycle gets an answer every cycle
    // The answer never depends on the write flag, so writes time like reads
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req.valid;
        end
    end

    // Read data: writes return zero and change nothing [RL14]
    // Data holds between answers, so a slow reader may still take it late
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (req.valid && !req.write) begin
            rdata_q <= read_mux; // [RL1] [RL4]
        end else if (req.valid) begin
            rdata_q <= 32'h0000_0000; // [RL14]
        end else begin
            rdata_q <= rdata_q; // Idle: hold the last answer
        end
    end

    // Error flag marks an answer to an unmapped or misaligned address
    // A pulse like the answer itself; it drops on the next idle cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else if (req.valid) begin
            err_q <= !(hit_version || hit_struct);
        end else begin
            err_q <= 1'b0;
        end
    end

    // Start of operational space for the neighbouring register block
    // Registered so the consumer sees a flop, not a parameter fan-out
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            op_base_q <= ECR_RST_CAP_LENGTH;
        end else begin
            op_base_q <= caps.capability_length; // [RL3]
        end
    end

    // Companion presence steers port ownership hand-off
    // Both levels come from one field, so they can never disagree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            handoff_supported_q <= 1'b0;
            high_speed_only_q   <= 1'b1;
        end else begin
            handoff_supported_q <= (caps.companion_count != 4'h0); // [RL7]
            high_speed_only_q   <= (caps.companion_count == 4'h0); // [RL6]
        end
    end

    // Routing mode for the port router: grouped or explicit array
    // Grouped routing maps port groups to companions in ascending order
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            explicit_routing_q <= 1'b0;
        end else begin
            explicit_routing_q <= caps.routing_rule; // [RL10] [RL11]
        end
    end

    // A bad parameter set is flagged, not hidden, so bring-up sees it
    // Zero ports or too few grouped ports leave this low after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            config_ok_q <= 1'b0;
        end else begin
            config_ok_q <= cfg_ok; // [RL9]
        end
    end

endmodule

`default_nettype wire

// File: ecr_capability_regs_assertions.sv
// Port-level checker for the capability register bank
`timescale 1ns/1ns
`default_nettype none
module ecr_cap_chk (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [7:0]  req_addr,
    input wire logic        ack_q,
    input wire logic [31:0] rdata_q,
    input wire logic        err_q,
    input wire logic [7:0]  op_base_q,
    input wire logic        handoff_supported_q,
    input wire logic        high_speed_only_q,
    input wire logic        explicit_routing_q,
    input wire logic        config_ok_q
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Read request at any address
    wire rd = req_valid && !req_write;
    a_ack_one_cycle: assert property (req_valid |=> ack_q && $past(req_valid))
        else $error("ack missing one cycle after request");
    a_ack_no_spur: assert property (!req_valid |=> !ack_q && !err_q)
        else $error("answer without request");
    a_version_word: assert property (rd && req_addr == 8'h00 |=> rdata_q == 32'h01000020)
        else $error("version word wrong");
    a_struct_word: assert property (rd && req_addr == 8'h04 |=> rdata_q == 32'h00002192)
        else $error("structural word wrong");
    a_write_no_data: assert property (req_valid && req_write |=> rdata_q == 32'h0)
        else $error("write answered with data");
    a_unmapped_err: assert property (req_valid && req_addr != 8'h00 && req_addr != 8'h04
        |=> err_q && rdata_q == 32'h0)
        else $error("unmapped access not refused");
    a_rdata_holds: assert property (!req_valid |=> $stable(rdata_q))
        else $error("read data changed without request");
    a_op_base_len: assert property (op_base_q == 8'h20)
        else $error("operational base offset wrong");
    a_companion_flags: assert property (ack_q |-> handoff_supported_q && !high_speed_only_q)
        else $error("companion flags wrong");
    a_routing_flags: assert property (ack_q |-> explicit_routing_q && config_ok_q)
        else $error("routing flags wrong");
    c_read_ver: cover property (rd && req_addr == 8'h00 ##1 ack_q);
    c_back2back: cover property (req_valid ##1 req_valid ##1 ack_q);
    c_refused: cover property (err_q);
endmodule
bind ecr_capability_regs ecr_cap_chk u_chk (.clock, .resetn, .req_valid, .req_write,
    .req_addr, .ack_q, .rdata_q, .err_q, .op_base_q, .handoff_supported_q,
    .high_speed_only_q, .explicit_routing_q, .config_ok_q);
`default_nettype wire

// File: ecr_capability_regs_tb.sv
// Self-checking bench for the capability register bank
`timescale 1ns/1ns
`default_nettype none
module ecr_capability_regs_tb;
    logic        clock, resetn, req_valid, req_write;
    logic [7:0]  req_addr, op_base_q;
    logic [31:0] req_wdata, rdata_q;
    logic        ack_q, err_q, handoff_supported_q, high_speed_only_q;
    logic        explicit_routing_q, config_ok_q;
    int          fail_count = 0;
    int          cmp_count = 0;
    // One access: write flag, address, expected data, expected refusal
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] x;
        logic        e;
    } ecr_row_t;
    // Writes to the mapped words come first so the reads after them prove nothing changed
    ecr_row_t rows [7] = '{
        '{1'b1, 8'h00, 32'h0, 1'b0},
        '{1'b1, 8'h04, 32'h0, 1'b0},
        '{1'b0, 8'h00, 32'h01000020, 1'b0},
        '{1'b0, 8'h04, 32'h00002192, 1'b0},
        '{1'b0, 8'h08, 32'h0, 1'b1},
        '{1'b0, 8'h02, 32'h0, 1'b1},
        '{1'b1, 8'hFC, 32'h0, 1'b1}
    };
    ecr_capability_regs DUT (.clock, .resetn, .req_valid, .req_write, .req_addr,
        .req_wdata, .ack_q, .rdata_q, .err_q, .op_base_q, .handoff_supported_q,
        .high_speed_only_q, .explicit_routing_q, .config_ok_q);
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Compare and count
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        cmp_count++;
        if (s !== x) begin
            $display("[ERR] %s expected %h seen %h", n, x, s);
            fail_count++;
        end
    endtask
    // Present a request at the falling edge; all-ones data must never land
    task automatic issue(input logic w, input logic [7:0] a);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = 32'hFFFFFFFF;
    endtask
    // One access with the answer and its one-cycle pulse checked
    task automatic run_row(input ecr_row_t r);
        @(negedge clock);
        issue(r.wr, r.a);
        @(negedge clock);
        req_valid = 1'b0;
        chk("ack", 32'h1, {31'h0, ack_q});
        chk("err", {31'h0, r.e}, {31'h0, err_q});
        chk("rdata", r.x, rdata_q);
        @(negedge clock);
        chk("ack_end", 32'h0, {31'h0, ack_q});
        chk("rdata_hold", r.x, rdata_q);
    endtask
    // Level outputs, packed as op_base, handoff, hs_only, explicit, config_ok
    task automatic levels(input logic [31:0] x);
        chk("levels", x, {20'h0, op_base_q, handoff_supported_q, high_speed_only_q,
            explicit_routing_q, config_ok_q});
    endtask
    task automatic conclude();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog well past the expected few dozen cycles
    initial begin
        #40000;
        fail_count++;
        conclude();
    end
    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 8'h00;
        req_wdata = 32'h0;
        repeat (8) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        levels(32'h20B);
        foreach (rows[i]) run_row(rows[i]);
        // Back-to-back reads, one answer per cycle
        @(negedge clock);
        issue(1'b0, 8'h00);
        @(negedge clock);
        chk("b2b_first", 32'h01000020, rdata_q);
        issue(1'b0, 8'h04);
        @(negedge clock);
        req_valid = 1'b0;
        chk("b2b_second", 32'h00002192, rdata_q);
        chk("b2b_ack", 32'h1, {31'h0, ack_q});
        // Reset in mid-run: outputs drop to their reset levels
        resetn = 1'b0;
        @(negedge clock);
        chk("rst_ack", 32'h0, {31'h0, ack_q});
        chk("rst_rdata", 32'h0, rdata_q);
        levels(32'h204);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        levels(32'h20B);
        run_row(rows[3]);
        conclude();
    end
endmodule
`default_nettype wire

// File: ecr_pkg.sv
// Shared constants and types for the capability register bank
`default_nettype none

package ecr_pkg;

    // Register byte offsets from the memory base
    localparam logic [7:0]  ECR_OFS_CAP_VERSION = 8'h00;
    localparam logic [7:0]  ECR_OFS_STRUCT_PARAMS = 8'h04;

    // Field positions in the version word
    localparam int          ECR_VER_LSB = 16;
    localparam int          ECR_CAPLEN_LSB = 0;

    // Field positions in the structural parameters word
    localparam int          ECR_COMPANIONS_LSB = 12;
    localparam int          ECR_PER_COMPANION_LSB = 8;
    localparam int          ECR_ROUTING_BIT = 7;
    localparam int          ECR_POWER_SWITCH_BIT = 4;
    localparam int          ECR_NPORTS_LSB = 0;

    // Values after reset
    localparam logic [15:0] ECR_RST_VERSION = 16'h0100;
    localparam logic [7:0]  ECR_RST_CAP_LENGTH = 8'h20;
    localparam logic [3:0]  ECR_RST_COMPANIONS = 4'h2;
    localparam logic [3:0]  ECR_RST_PORTS_PER_CC = 4'h1;
    localparam logic        ECR_RST_ROUTING_RULE = 1'b1;
    localparam logic        ECR_RST_POWER_SWITCH = 1'b1;
    localparam logic [3:0]  ECR_RST_PORT_COUNT = 4'h2;

    // Cycles from a taken request to its answer
    localparam int          ECR_ANSWER_CYCLES = 1;

    // Static capability fields as one carrier
    typedef struct packed {
        logic [15:0] interface_version;
        logic [7:0]  capability_length;
        logic [3:0]  companion_count;
        logic [3:0]  ports_per_companion;
        logic        routing_rule;
        logic        power_switch_present;
        logic [3:0]  port_count;
    } ecr_caps_t;

    // Register access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ecr_req_t;

endpackage

`default_nettype wire

// File: ecr_word_pack.sv
// Packs capability fields into the two register words and checks them
`timescale 1ns/1ns
`default_nettype none

module ecr_word_pack
    import ecr_pkg::*;
(
    input  wire ecr_caps_t   caps,
    output logic [31:0]      version_word,
    output logic [31:0]      struct_word,
    output logic             config_ok
);

    // Widened products for the port grouping check
    logic [7:0] group_span;

    // Version word: reserved bits 15..8 forced to zero [RL1] [RL14]
    always_comb begin
        version_word = 32'h0000_0000;
        version_word[ECR_VER_LSB +: 16] = caps.interface_version; // [RL1] [RL2]
        version_word[ECR_CAPLEN_LSB +: 8] = caps.capability_length; // [RL1] [RL3]
    end

    // Structural word: bits 31..16 and 6..5 stay zero [RL4] [RL14]
    always_comb begin
        struct_word = 32'h0000_0000;
        struct_word[ECR_COMPANIONS_LSB +: 4] = caps.companion_count; // [RL5]
        struct_word[ECR_PER_COMPANION_LSB +: 4] = caps.ports_per_companion; // [RL8]
        struct_word[ECR_ROUTING_BIT] = caps.routing_rule; // [RL10] [RL11]
        struct_word[ECR_POWER_SWITCH_BIT] = caps.power_switch_present; // [RL12]
        struct_word[ECR_NPORTS_LSB +: 4] = caps.port_count; // [RL13]
    end

    // Groups of ports_per_companion must cover every port [RL9]
    always_comb begin
        group_span = {4'h0, caps.companion_count} * {4'h0, caps.ports_per_companion};
        if (caps.port_count == 4'h0) begin
            config_ok = 1'b0; // Zero ports is undefined [RL13]
        end else if (caps.companion_count == 4'h0) begin
            config_ok = (caps.ports_per_companion == 4'h0); // [RL6]
        end else begin
            config_ok = (group_span >= {4'h0, caps.port_count})
                     && (caps.ports_per_companion != 4'h0); // [RL7] [RL9]
        end
    end

endmodule

`default_nettype wire
